/* rtl/i2cs_top.v */
// Serial port in I2C mode: slave transmitter, start/stop flags, open-drain pin control
//
// Behaviour
// - Matching read address sets read/write flag and loads address into buffer.
// - After matching read address, acknowledge on ninth bit, then hold SCL low.
// - Firmware write to buffer is copied into shift register at once.
// - Stretched SCL released only when firmware sets clock release bit.
// - Transmit bits change on falling SCL, stable while SCL high.
// - Interrupt flag set on ninth falling SCL edge, stays until firmware clears.
// - Master acknowledge sampled on ninth rising SCL edge.
// - No acknowledge ends transfer, resets slave, read/write and buffer full flags, waits start.
// - Acknowledge low: SCL held low until firmware reloads and releases.
// - Start and stop flags cleared on reset and while port disabled.
// - Start and stop flags follow the last bus condition seen.
// - Enabled port drives a pin low whenever its direction bit says output.
// - Interrupt flag set on each byte completed; on start and stop only in modes 1011, 1110, 1111.
// - Mode 1011 gives start/stop interrupts with slave idle.
// - Shift bits 7..1 compared with own address on eighth falling SCL.
// - Buffer full or overflow set: no acknowledge, no load, flag still set.
// - Buffer read clears buffer full; overflow cleared only by firmware write.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "i2cs_regs.vh"

module i2cs_top (
    input wire pclk, // System clock
    input wire presetn, // Asynchronous reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction, high for write
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output wire pready, // APB ready
    output reg [31:0] prdata, // APB read data
    output wire pslverr, // APB error on unmapped address
    input wire scl_i, // Clock line level
    output reg scl_o, // Clock line drive value
    output reg scl_oe_n, // Clock line drive enable, low drives
    input wire sda_i, // Data line level
    output reg sda_o, // Data line drive value
    output reg sda_oe_n // Data line drive enable, low drives
);

// ----------------------------------------------------------------
// State codes
// ----------------------------------------------------------------
localparam ST_IDLE = 3'h0;
localparam ST_ADDR = 3'h1;
localparam ST_RXD = 3'h2;
localparam ST_HOLD = 3'h3;
localparam ST_TX = 3'h4;
localparam ST_MACK = 3'h5;

reg [7:0] rx_tx_buffer_r, serial_shift_reg_r, own_address_reg_r;
reg [7:0] port_c_direction_r, port_c_latch_r;
reg [3:0] mode_select_field_r;
reg enable_r, overflow_flag_r, clock_release_bit_r, wcol_r;
reg buffer_full_flag_r, rw_flag_r, start_flag_r, stop_flag_r, port_irq_flag_r;
reg [2:0] st_r;
reg [3:0] cnt_r;
reg ack_drv_r, mack_r;
reg [1:0] sy1_r, sy2_r, sy3_r, lv_r, lvd_r;

// ----------------------------------------------------------------
// Line synchroniser, bit 0 is SCL, bit 1 is SDA
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        sy1_r <= 2'h3;
        sy2_r <= 2'h3;
        sy3_r <= 2'h3;
        lv_r <= 2'h3;
        lvd_r <= 2'h3;
    end
    else
    begin
        sy1_r <= {sda_i, scl_i};
        sy2_r <= sy1_r;
        sy3_r <= sy2_r;
        lv_r <= (sy2_r & sy3_r) | (lv_r & (sy2_r | sy3_r));
        lvd_r <= lv_r;
    end
end

wire scl_rise = lv_r[0] & ~lvd_r[0];
wire scl_fall = ~lv_r[0] & lvd_r[0];
wire start_seen = lv_r[0] & lvd_r[0] & lvd_r[1] & ~lv_r[1];
wire stop_seen = lv_r[0] & lvd_r[0] & ~lvd_r[1] & lv_r[1];
wire sda_lv = lv_r[1];

// ----------------------------------------------------------------
// Mode decode
// ----------------------------------------------------------------
wire slave_en = enable_r & ((mode_select_field_r == `I2CS_MODE_S7) |
    (mode_select_field_r == `I2CS_MODE_S10) | (mode_select_field_r == `I2CS_MODE_S7SS) |
    (mode_select_field_r == `I2CS_MODE_S10SS));
wire ss_irq_en = enable_r & ((mode_select_field_r == `I2CS_MODE_MASTER) |
    (mode_select_field_r == `I2CS_MODE_S7SS) | (mode_select_field_r == `I2CS_MODE_S10SS));
wire i2c_en = slave_en | ss_irq_en;

// ----------------------------------------------------------------
// APB decode
// ----------------------------------------------------------------
wire map_hit = (paddr == `I2CS_A_BUF) | (paddr == `I2CS_A_ADDR) | (paddr == `I2CS_A_CTL) |
    (paddr == `I2CS_A_STAT) | (paddr == `I2CS_A_IRQ) | (paddr == `I2CS_A_DIR) |
    (paddr == `I2CS_A_LAT);
wire acc = psel & penable;
wire wr = acc & pwrite & map_hit;
wire rd = acc & ~pwrite & map_hit;
wire setup = psel & ~penable;

assign pready = 1'b1;
assign pslverr = acc & ~map_hit;

reg [7:0] rd_mux;
always @*
begin
    rd_mux = `I2CS_RST_BYTE;
    case (paddr)
        `I2CS_A_BUF: rd_mux = rx_tx_buffer_r;
        `I2CS_A_ADDR: rd_mux = own_address_reg_r;
        `I2CS_A_CTL: rd_mux = {wcol_r, overflow_flag_r, enable_r, clock_release_bit_r,
            mode_select_field_r};
        `I2CS_A_STAT: rd_mux = {3'h0, stop_flag_r, start_flag_r, rw_flag_r, 1'b0,
            buffer_full_flag_r};
        `I2CS_A_IRQ: rd_mux = {4'h0, port_irq_flag_r, 3'h0};
        `I2CS_A_DIR: rd_mux = port_c_direction_r;
        `I2CS_A_LAT: rd_mux = port_c_latch_r;
        default: rd_mux = `I2CS_RST_BYTE;
    endcase
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        prdata <= 32'h0000_0000;
    else if (setup)
        prdata <= {24'h00_0000, rd_mux};
end

// ----------------------------------------------------------------
// Registers and slave sequencer; firmware first, hardware sets last
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        rx_tx_buffer_r <= `I2CS_RST_BYTE;
        serial_shift_reg_r <= `I2CS_RST_BYTE;
        own_address_reg_r <= `I2CS_RST_BYTE;
        port_c_direction_r <= `I2CS_RST_DIR;
        port_c_latch_r <= `I2CS_RST_BYTE;
        mode_select_field_r <= 4'h0;
        enable_r <= 1'b0;
        overflow_flag_r <= 1'b0;
        clock_release_bit_r <= 1'b0;
        wcol_r <= 1'b0;
        buffer_full_flag_r <= 1'b0;
        rw_flag_r <= 1'b0;
        start_flag_r <= 1'b0;
        stop_flag_r <= 1'b0;
        port_irq_flag_r <= 1'b0;
        st_r <= ST_IDLE;
        cnt_r <= `I2CS_CNT_ZERO;
        ack_drv_r <= 1'b0;
        mack_r <= 1'b1;
    end
    else
    begin
        if (wr)
        begin
            case (paddr)
                `I2CS_A_BUF:
                begin
                    rx_tx_buffer_r <= pwdata[7:0];
                    serial_shift_reg_r <= pwdata[7:0];
                end
                `I2CS_A_ADDR: own_address_reg_r <= pwdata[7:0];
                `I2CS_A_CTL:
                begin
                    wcol_r <= pwdata[7];
                    overflow_flag_r <= pwdata[`I2CS_CTL_OV];
                    enable_r <= pwdata[`I2CS_CTL_EN];
                    clock_release_bit_r <= pwdata[`I2CS_CTL_CKP];
                    mode_select_field_r <= pwdata[`I2CS_CTL_MH:`I2CS_CTL_ML];
                end
                `I2CS_A_IRQ: port_irq_flag_r <= pwdata[`I2CS_IRQ_BIT];
                `I2CS_A_DIR: port_c_direction_r <= pwdata[7:0];
                `I2CS_A_LAT: port_c_latch_r <= pwdata[7:0];
                default: wcol_r <= wcol_r;
            endcase
        end
        if (rd && paddr == `I2CS_A_BUF)
            buffer_full_flag_r <= 1'b0;

        if (!i2c_en)
        begin
            start_flag_r <= 1'b0;
            stop_flag_r <= 1'b0;
        end
        else if (start_seen)
        begin
            start_flag_r <= 1'b1;
            stop_flag_r <= 1'b0;
            if (ss_irq_en)
                port_irq_flag_r <= 1'b1;
        end
        else if (stop_seen)
        begin
            stop_flag_r <= 1'b1;
            start_flag_r <= 1'b0;
            if (ss_irq_en)
                port_irq_flag_r <= 1'b1;
        end

        if (!slave_en)
        begin
            st_r <= ST_IDLE;
            ack_drv_r <= 1'b0;
            cnt_r <= `I2CS_CNT_ZERO;
        end
        else if (start_seen)
        begin
            st_r <= ST_ADDR;
            ack_drv_r <= 1'b0;
            cnt_r <= `I2CS_CNT_ZERO;
        end
        else if (stop_seen)
        begin
            st_r <= ST_IDLE;
            ack_drv_r <= 1'b0;
        end
        else
        begin
            case (st_r)
                ST_ADDR, ST_RXD:
                begin
                    if (scl_rise)
                    begin
                        if (cnt_r != `I2CS_CNT_BYTE)
                            serial_shift_reg_r <= {serial_shift_reg_r[6:0], sda_lv};
                        cnt_r <= cnt_r + `I2CS_CNT_ONE;
                    end
                    else if (scl_fall && cnt_r == `I2CS_CNT_BYTE)
                    begin
                        if (st_r == ST_ADDR &&
                            serial_shift_reg_r[7:1] != own_address_reg_r[7:1])
                            st_r <= ST_IDLE;
                        else if (!buffer_full_flag_r && !overflow_flag_r)
                        begin
                            rx_tx_buffer_r <= serial_shift_reg_r;
                            buffer_full_flag_r <= 1'b1;
                            ack_drv_r <= 1'b1;
                            if (st_r == ST_ADDR)
                                rw_flag_r <= serial_shift_reg_r[0];
                        end
                        else
                        begin
                            if (buffer_full_flag_r)
                                overflow_flag_r <= 1'b1;
                            if (st_r == ST_ADDR)
                                rw_flag_r <= serial_shift_reg_r[0];
                        end
                    end
                    else if (scl_fall && cnt_r == `I2CS_CNT_ACK)
                    begin
                        port_irq_flag_r <= 1'b1;
                        ack_drv_r <= 1'b0;
                        cnt_r <= `I2CS_CNT_ZERO;
                        if (st_r == ST_ADDR && rw_flag_r && ack_drv_r)
                        begin
                            st_r <= ST_HOLD;
                            clock_release_bit_r <= 1'b0;
                        end
                        else if (st_r == ST_ADDR && rw_flag_r)
                            st_r <= ST_IDLE;
                        else
                            st_r <= ST_RXD;
                    end
                end
                ST_HOLD:
                begin
                    if (clock_release_bit_r)
                    begin
                        st_r <= ST_TX;
                        cnt_r <= `I2CS_CNT_ZERO;
                    end
                end
                ST_TX:
                begin
                    if (scl_rise)
                        cnt_r <= cnt_r + `I2CS_CNT_ONE;
                    else if (scl_fall)
                    begin
                        if (cnt_r == `I2CS_CNT_BYTE)
                            st_r <= ST_MACK;
                        else
                            serial_shift_reg_r <= {serial_shift_reg_r[6:0], 1'b0};
                    end
                end
                ST_MACK:
                begin
                    if (scl_rise)
                    begin
                        mack_r <= sda_lv;
                        cnt_r <= `I2CS_CNT_ACK;
                    end
                    else if (scl_fall && cnt_r == `I2CS_CNT_ACK)
                    begin
                        port_irq_flag_r <= 1'b1;
                        cnt_r <= `I2CS_CNT_ZERO;
                        if (mack_r)
                        begin
                            st_r <= ST_IDLE;
                            rw_flag_r <= 1'b0;
                            buffer_full_flag_r <= 1'b0;
                        end
                        else
                        begin
                            st_r <= ST_HOLD;
                            clock_release_bit_r <= 1'b0;
                        end
                    end
                end
                default: cnt_r <= `I2CS_CNT_ZERO;
            endcase
        end
    end
end

// ----------------------------------------------------------------
// Pin drive: I2C forces low only; disabled port acts as plain output
// ----------------------------------------------------------------
wire slave_scl_low = (st_r == ST_HOLD) & ~clock_release_bit_r;
// First bit goes out during the stretch, so SDA is settled before SCL is let go
wire tx_drive = (st_r == ST_TX) | (st_r == ST_HOLD);
wire slave_sda_low = ack_drv_r | (tx_drive & ~serial_shift_reg_r[7]);

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        scl_o <= 1'b1;
        scl_oe_n <= 1'b1;
        sda_o <= 1'b1;
        sda_oe_n <= 1'b1;
    end
    else if (i2c_en)
    begin
        scl_o <= 1'b0;
        sda_o <= 1'b0;
        scl_oe_n <= port_c_direction_r[`I2CS_PIN_SCL] & ~slave_scl_low;
        sda_oe_n <= port_c_direction_r[`I2CS_PIN_SDA] & ~slave_sda_low;
    end
    else
    begin
        scl_o <= port_c_latch_r[`I2CS_PIN_SCL];
        sda_o <= port_c_latch_r[`I2CS_PIN_SDA];
        scl_oe_n <= port_c_direction_r[`I2CS_PIN_SCL];
        sda_oe_n <= port_c_direction_r[`I2CS_PIN_SDA];
    end
end

endmodule

/* rtl/i2cs_regs.vh */
// Register map, field positions and codes of the serial port in I2C mode
`ifndef I2CS_REGS_VH
`define I2CS_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define I2CS_A_BUF 8'h00
`define I2CS_A_ADDR 8'h04
`define I2CS_A_CTL 8'h08
`define I2CS_A_STAT 8'h0c
`define I2CS_A_IRQ 8'h10
`define I2CS_A_DIR 8'h14
`define I2CS_A_LAT 8'h18

// ----------------------------------------------------------------
// port_control_reg fields
// ----------------------------------------------------------------
`define I2CS_CTL_OV 6
`define I2CS_CTL_EN 5
`define I2CS_CTL_CKP 4
`define I2CS_CTL_MH 3
`define I2CS_CTL_ML 0

// ----------------------------------------------------------------
// port_status_reg fields
// ----------------------------------------------------------------
`define I2CS_ST_P 4
`define I2CS_ST_S 3
`define I2CS_ST_RW 2
`define I2CS_ST_BF 0

// ----------------------------------------------------------------
// peripheral_irq_flags and port direction/latch fields
// ----------------------------------------------------------------
`define I2CS_IRQ_BIT 3
`define I2CS_PIN_SDA 4
`define I2CS_PIN_SCL 3

// ----------------------------------------------------------------
// Mode codes, reset values, counts
// ----------------------------------------------------------------
`define I2CS_MODE_MASTER 4'hb
`define I2CS_MODE_S7 4'h6
`define I2CS_MODE_S10 4'h7
`define I2CS_MODE_S7SS 4'he
`define I2CS_MODE_S10SS 4'hf
`define I2CS_RST_BYTE 8'h00
`define I2CS_RST_DIR 8'hff
`define I2CS_CNT_ZERO 4'h0
`define I2CS_CNT_ONE 4'h1
`define I2CS_CNT_BYTE 4'h8
`define I2CS_CNT_ACK 4'h9

`endif

/* verif/i2cs_top_properties.sv */
// Port assertions for the I2C serial port block
`timescale 1ns/10ps
`include "i2cs_regs.vh"
module i2cs_top_properties (
    input wire pclk, // Clock
    input wire presetn, // Reset, active low
    input wire psel, // Select
    input wire penable, // Enable
    input wire pwrite, // Direction
    input wire [7:0] paddr, // Address
    input wire [31:0] pwdata, // Write data
    input wire pready, // Ready
    input wire [31:0] prdata, // Read data
    input wire pslverr, // Error
    input wire scl_i, // Clock line
    input wire scl_o, // Clock drive value
    input wire scl_oe_n, // Clock drive enable
    input wire sda_i, // Data line
    input wire sda_o, // Data drive value
    input wire sda_oe_n // Data drive enable
);
    // ----------------------------------------------------------------
    // Shadow of enable, mode and direction
    // ----------------------------------------------------------------
    reg en_r;
    reg [3:0] mode_r;
    reg [7:0] dir_r;
    reg [2:0] quiet_r;
    wire wr_w = psel && penable && pwrite;
    wire ctl_w = wr_w && paddr == `I2CS_A_CTL;
    wire i2c_w = en_r && (mode_r == `I2CS_MODE_S7 || mode_r == `I2CS_MODE_MASTER);
    wire slv_w = en_r && mode_r == `I2CS_MODE_S7 && dir_r[4:3] == 2'b11;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_r <= 1'b0;
            mode_r <= 4'h0;
            dir_r <= 8'hff;
            quiet_r <= 3'h0;
        end
        else
        begin
            if (ctl_w)
            begin
                en_r <= pwdata[`I2CS_CTL_EN];
                mode_r <= pwdata[3:0];
            end
            if (wr_w && paddr == `I2CS_A_DIR)
                dir_r <= pwdata[7:0];
            quiet_r <= wr_w ? 3'h0 : (quiet_r == 3'h4 ? quiet_r : quiet_r + 3'h1);
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_rel;
        ctl_w && pwdata[`I2CS_CTL_CKP] && !scl_oe_n && i2c_w && dir_r[3];
    endsequence
    property p_rel;
        s_rel |-> ##[1:4] scl_oe_n;
    endproperty
    property p_hold;
        i2c_w && dir_r[3] && !scl_oe_n && quiet_r == 3'h4 |=> !scl_oe_n;
    endproperty
    property p_sda_stb;
        (slv_w && scl_i)[*3] |-> $stable(sda_oe_n);
    endproperty
    property p_mst_sda;
        (i2c_w && !dir_r[4])[*2] |-> !sda_oe_n && !sda_o;
    endproperty
    property p_mst_scl;
        (i2c_w && !dir_r[3])[*2] |-> !scl_oe_n && !scl_o;
    endproperty
    property p_off;
        (!en_r && dir_r[4:3] == 2'b11)[*2] |-> sda_oe_n && scl_oe_n;
    endproperty
    property p_lowv;
        i2c_w[*2] |-> !sda_o && !scl_o;
    endproperty
    property p_err;
        !(psel && penable) |-> !pslverr;
    endproperty
    a_rel: assert property (p_rel) else $error("clock line not released");
    a_hold: assert property (p_hold) else $error("stretch ended early");
    a_sda_stb: assert property (p_sda_stb) else $error("data moved while clock high");
    a_mst_sda: assert property (p_mst_sda) else $error("data pin not driven low");
    a_mst_scl: assert property (p_mst_scl) else $error("clock pin not driven low");
    a_off: assert property (p_off) else $error("pin driven while disabled");
    a_lowv: assert property (p_lowv) else $error("drive value not low");
    a_err: assert property (p_err) else $error("error outside access phase");
endmodule
bind i2cs_top i2cs_top_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n));

/* verif/i2cs_bus_master.sv */
// Behavioural bus master that clocks the port from the far side
`timescale 1ns/10ps
module i2cs_bus_master (
    input wire scl_line, // Resolved clock line
    input wire sda_line, // Resolved data line
    output reg scl_d, // Clock drive, low pulls down
    output reg sda_d // Data drive, low pulls down
);
    initial
    begin
        scl_d = 1'b1;
        sda_d = 1'b1;
    end
    // Low phase is long enough for the filtered slave to move data
    task bit_io(input logic b, output logic r);
    begin
        #307 sda_d = b;
        #200 scl_d = 1'b1;
        wait (scl_line === 1'b1);
        #113 r = sda_line;
        #100 scl_d = 1'b0;
    end
    endtask
    task start_c;
    begin
        #307 sda_d = 1'b1;
        #200 scl_d = 1'b1;
        #200 sda_d = 1'b0;
        #200 scl_d = 1'b0;
    end
    endtask
    task stop_c;
    begin
        #307 sda_d = 1'b0;
        #200 scl_d = 1'b1;
        wait (scl_line === 1'b1);
        #200 sda_d = 1'b1;
        #200;
    end
    endtask
    task byte_w(input logic [7:0] d, output logic ack);
        integer i;
        logic r;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bit_io(d[i], r);
        bit_io(1'b1, ack);
    end
    endtask
    task byte_r(input logic ack, output logic [7:0] d);
        integer i;
        logic r;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bit_io(1'b1, d[i]);
        bit_io(ack, r);
    end
    endtask
endmodule

/* verif/i2cs_top_test.sv */
// Self-checking bench for the I2C serial port block
`timescale 1ns/10ps
`include "i2cs_regs.vh"
module i2cs_top_test;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0000_0000;
    wire pready, pslverr, scl_o, scl_oe_n, sda_o, sda_oe_n, scl_d, sda_d;
    wire [31:0] prdata;
    wire scl_line = scl_d & (scl_oe_n | scl_o);
    wire sda_line = sda_d & (sda_oe_n | sda_o);
    integer n_errors = 0;
    integer num_checks = 0;
    logic [8:0] exp_q[$];
    logic [7:0] d0, d1, got;
    logic ack;
    always #25 pclk = ~pclk;
    i2cs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .scl_i(scl_line), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
    i2cs_bus_master u_mst (.scl_line(scl_line), .sda_line(sda_line), .scl_d(scl_d),
        .sda_d(sda_d));
    // ----------------------------------------------------------------
    // Compare, bus cycles and closing
    // ----------------------------------------------------------------
    task cmp(input logic [8:0] got_v, input logic [8:0] exp_v);
    begin
        num_checks = num_checks + 1;
        if (got_v !== exp_v)
        begin
            n_errors = n_errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    end
    endtask
    task apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    begin
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(a, 1'b1, d);
    endtask
    task rd(input logic [7:0] a, input logic [8:0] e);
    begin
        exp_q.push_back(e);
        apb(a, 1'b0, 8'h00);
    end
    endtask
    task close_out;
    begin
        $display("Checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    // Read results are matched against the oldest expectation
    always @(posedge pclk)
    begin
        if (psel && penable && !pwrite && pready === 1'b1)
            cmp({pslverr, prdata[7:0]}, exp_q.pop_front());
    end
    initial
    begin
        #500_000;
        n_errors = n_errors + 1;
        close_out;
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        d0 = $urandom(16017);
        d1 = $urandom;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(`I2CS_A_DIR, 9'h0ff);
        rd(`I2CS_A_STAT, 9'h000);
        rd(8'h40, 9'h100);
        wr(`I2CS_A_ADDR, 8'hb4);
        wr(`I2CS_A_CTL, 8'h26);
        u_mst.start_c;
        rd(`I2CS_A_STAT, 9'h008);
        rd(`I2CS_A_IRQ, 9'h000);
        u_mst.byte_w(8'hb5, ack);
        cmp({8'h00, ack}, 9'h000);
        rd(`I2CS_A_STAT, 9'h00d);
        rd(`I2CS_A_BUF, 9'h0b5);
        rd(`I2CS_A_STAT, 9'h00c);
        rd(`I2CS_A_IRQ, 9'h008);
        wr(`I2CS_A_IRQ, 8'h00);
        rd(`I2CS_A_IRQ, 9'h000);
        cmp({8'h00, scl_oe_n}, 9'h000);
        wr(`I2CS_A_BUF, d0);
        wr(`I2CS_A_CTL, 8'h36);
        u_mst.byte_r(1'b0, got);
        cmp({1'b0, got}, {1'b0, d0});
        repeat (20) @(posedge pclk);
        cmp({8'h00, scl_oe_n}, 9'h000);
        wr(`I2CS_A_BUF, d1);
        wr(`I2CS_A_CTL, 8'h36);
        u_mst.byte_r(1'b1, got);
        cmp({1'b0, got}, {1'b0, d1});
        repeat (20) @(posedge pclk);
        cmp({8'h00, scl_oe_n}, 9'h001);
        u_mst.stop_c;
        rd(`I2CS_A_STAT, 9'h010);
        u_mst.start_c;
        u_mst.byte_w(8'h12, ack);
        cmp({8'h00, ack}, 9'h001);
        u_mst.stop_c;
        wr(`I2CS_A_CTL, 8'h26);
        u_mst.start_c;
        u_mst.byte_w(8'hb4, ack);
        cmp({8'h00, ack}, 9'h000);
        u_mst.byte_w(d0, ack);
        cmp({8'h00, ack}, 9'h001);
        u_mst.stop_c;
        rd(`I2CS_A_CTL, 9'h066);
        wr(`I2CS_A_CTL, 8'h26);
        rd(`I2CS_A_CTL, 9'h026);
        rd(`I2CS_A_BUF, 9'h0b4);
        rd(`I2CS_A_STAT, 9'h010);
        wr(`I2CS_A_IRQ, 8'h00);
        wr(`I2CS_A_CTL, 8'h2e);
        u_mst.start_c;
        rd(`I2CS_A_IRQ, 9'h008);
        rd(`I2CS_A_STAT, 9'h008);
        u_mst.stop_c;
        wr(`I2CS_A_IRQ, 8'h00);
        wr(`I2CS_A_CTL, 8'h2b);
        u_mst.start_c;
        rd(`I2CS_A_IRQ, 9'h008);
        wr(`I2CS_A_IRQ, 8'h00);
        u_mst.stop_c;
        rd(`I2CS_A_IRQ, 9'h008);
        rd(`I2CS_A_STAT, 9'h010);
        wr(`I2CS_A_LAT, 8'hff);
        wr(`I2CS_A_DIR, 8'he7);
        repeat (4) @(posedge pclk);
        cmp({5'h00, sda_oe_n, sda_o, scl_oe_n, scl_o}, 9'h000);
        wr(`I2CS_A_DIR, 8'hff);
        wr(`I2CS_A_CTL, 8'h00);
        rd(`I2CS_A_STAT, 9'h000);
        close_out;
    end
endmodule
